// ==== rtl/ebtmr_timer.sv ====
// Eight-bit event timer channel with compare, square wave and PWM output
// Notes on behaviour
// - Eight-bit up-counter, read-only to software
// - Counter advances once per selected count pulse
// - Counter zeroed by reset, stop, clear-mode match
// - Non-PWM match raises the match interrupt
// - PWM match makes output inactive, no interrupt
// - Compare register fully readable and writable
// - Reset loads compare register with zero
// - Codes 000/001 pick event falling/rising edge
// - First channel divides by 1,2,4,64,256,8192
// - Second channel divides by 1,2,16,64,256,4096
// - Reset selects event falling edge as source
// - Run bit starts counting; clearing zeroes and stops
// - Mode bit picks clear-and-restart or free PWM
// - Output low unless output enable set
// - Stopping in PWM forces output inactive
//
// The APB register port was decided locally.
`timescale 1ns/10ps

module ebtmr_timer
  import ebtmr_pkg::*;
#(
  parameter bit SECOND_CHANNEL = 1'b0
)
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [EBTMR_ADDR_W-1:0] paddr,
  input  wire logic [EBTMR_DATA_W-1:0] pwdata,
  output logic      [EBTMR_DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    event_input_pin,
  output logic                         timer_output_pin,
  output logic                         match_irq
);

  // ==========================================================================
  // Channel-dependent register map
  // ==========================================================================
  localparam logic [15:0] IDX_SRC   = SECOND_CHANNEL ? EBTMR_IDX_SRC_B
                                                     : EBTMR_IDX_SRC_A;
  localparam logic [15:0] IDX_MODE  = SECOND_CHANNEL ? EBTMR_IDX_MODE_B
                                                     : EBTMR_IDX_MODE_A;
  localparam logic [15:0] IDX_COUNT = SECOND_CHANNEL ? EBTMR_IDX_COUNT_B
                                                     : EBTMR_IDX_COUNT_A;
  localparam logic [15:0] IDX_MATCH = SECOND_CHANNEL ? EBTMR_IDX_MATCH_B
                                                     : EBTMR_IDX_MATCH_A;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [EBTMR_PRESC_W-1:0] presc;
    logic [EBTMR_SRC_W-1:0]   src_sel;
    logic                     run;
    logic                     pwm;
    logic                     level_sel;
    logic                     out_en;
    logic [EBTMR_REG_W-1:0]   count;
    logic [EBTMR_REG_W-1:0]   match;
    logic                     timer_ff;
    logic                     pwm_ff;
    logic                     pin;
    logic                     irq;
    logic [EBTMR_REG_W-1:0]   rdata;
    logic                     slverr;
  } ebtmr_state_type;

  ebtmr_state_type st;
  ebtmr_state_type next_st;

  logic                     ev_pulse;
  logic                     ev_rising;
  logic [3:0]               tap;
  logic [EBTMR_PRESC_W-1:0] tap_mask;
  logic                     div_tick;
  logic                     count_pulse;
  logic [EBTMR_IDX_W-1:0]   idx;
  logic                     aligned;
  logic                     hit;
  logic                     setup_ph;
  logic                     wr_acc;
  logic [EBTMR_REG_W-1:0]   mode_rd;
  logic [EBTMR_REG_W-1:0]   rd_mux;
  logic [EBTMR_REG_W-1:0]   wbyte;

  // ==========================================================================
  // Event input edge detector
  // ==========================================================================
  assign ev_rising = (st.src_sel == EBTMR_SRC_EV_RISE);

  ebtmr_event_edge u_event_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .event_in   (event_input_pin),
    .rising_sel (ev_rising),
    .edge_pulse (ev_pulse)
  );

  // ==========================================================================
  // Count source selection
  // ==========================================================================
  // Tap lookup; event codes fall outside the divider range
  always_comb
  begin
    tap = 4'h0;
    if (st.src_sel >= EBTMR_SRC_DIV_LO)
    begin
      if (SECOND_CHANNEL)
        tap = EBTMR_TAPS_B[st.src_sel - EBTMR_SRC_DIV_LO];
      else
        tap = EBTMR_TAPS_A[st.src_sel - EBTMR_SRC_DIV_LO];
    end
  end

  // Tick when the low tap bits of the free prescaler are all ones
  assign tap_mask = ~({EBTMR_PRESC_W{1'b1}} << tap);
  assign div_tick = &(st.presc | ~tap_mask);

  // Divider ticks are shared with the channel, so a start may lose
  // up to one count period against the first match
  always_comb
  begin
    if (st.src_sel < EBTMR_SRC_DIV_LO)
      count_pulse = ev_pulse;
    else
      count_pulse = div_tick;
  end

  // ==========================================================================
  // APB decode
  // ==========================================================================
  assign idx      = paddr[EBTMR_ADDR_W-1:EBTMR_IDX_LSB];
  assign aligned  = (paddr[EBTMR_IDX_LSB-1:0] == EBTMR_ALIGN_OK);
  assign hit      = aligned && ((idx == IDX_SRC) || (idx == IDX_MODE) ||
                    (idx == IDX_COUNT) || (idx == IDX_MATCH));
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & ~st.slverr;
  assign wbyte    = pwdata[EBTMR_REG_W-1:0];

  // Flip-flop set and clear bits are write-only and read back zero
  always_comb
  begin
    mode_rd                   = '0;
    mode_rd[EBTMR_BIT_RUN]    = st.run;
    mode_rd[EBTMR_BIT_PWM]    = st.pwm;
    mode_rd[EBTMR_BIT_LEVEL]  = st.level_sel;
    mode_rd[EBTMR_BIT_OUT_EN] = st.out_en;
  end

  // Read mux; unused source bits read zero
  always_comb
  begin
    rd_mux = '0;
    if (aligned)
    begin
      case (idx)
        IDX_SRC:   rd_mux[EBTMR_SRC_W-1:0] = st.src_sel;
        IDX_MODE:  rd_mux = mode_rd;
        IDX_COUNT: rd_mux = st.count;
        IDX_MATCH: rd_mux = st.match;
        default:   rd_mux = '0;
      endcase
    end
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    next_st       = st;
    next_st.irq   = 1'b0;
    next_st.presc = st.presc + 1'b1;

    // Read data and error are captured in the setup cycle so that the
    // access cycle answers from flip-flops with no wait state
    if (setup_ph)
    begin
      next_st.rdata  = pwrite ? '0 : rd_mux;
      next_st.slverr = ~hit;
    end

    // Counter and output flip-flops
    if (!st.run)
    begin
      next_st.count  = EBTMR_RST_COUNT;
      next_st.pwm_ff = 1'b0;
    end
    else if (count_pulse)
    begin
      if (!st.pwm)
      begin
        if (st.count == st.match)
        begin
          next_st.count = EBTMR_RST_COUNT;
          next_st.irq   = 1'b1;
          if (st.level_sel)
            next_st.timer_ff = ~st.timer_ff;
        end
        else
          next_st.count = st.count + 1'b1;
      end
      else
      begin
        next_st.count = st.count + 1'b1;
        // Wrap starts the active phase
        if (st.count == EBTMR_COUNT_TOP)
          next_st.pwm_ff = 1'b1;
        // Match ends it without any interrupt
        if (st.count == st.match)
          next_st.pwm_ff = 1'b0;
      end
    end

    // Register writes take effect in the access cycle
    if (wr_acc)
    begin
      case (idx)
        IDX_SRC:
          next_st.src_sel = wbyte[EBTMR_SRC_W-1:0];
        IDX_MODE:
        begin
          next_st.run       = wbyte[EBTMR_BIT_RUN];
          next_st.pwm       = wbyte[EBTMR_BIT_PWM];
          next_st.level_sel = wbyte[EBTMR_BIT_LEVEL];
          next_st.out_en    = wbyte[EBTMR_BIT_OUT_EN];
          // Forcing the flip-flop only applies outside PWM;
          // both bits set is prohibited and ignored
          if (!wbyte[EBTMR_BIT_PWM] &&
              (wbyte[EBTMR_BIT_FF_SET] != wbyte[EBTMR_BIT_FF_CLR]))
            next_st.timer_ff = wbyte[EBTMR_BIT_FF_SET];
        end
        IDX_MATCH:
          next_st.match = wbyte;
        default:
          next_st.match = st.match;
      endcase
    end

    // Pin level follows mode, level and enable regardless of run
    if (!st.out_en)
      next_st.pin = 1'b0;
    else if (st.pwm)
      next_st.pin = st.pwm_ff ^ st.level_sel;
    else
      next_st.pin = st.timer_ff;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st         <= '0;
      st.count   <= EBTMR_RST_COUNT;
      st.match   <= EBTMR_RST_MATCH;
      st.src_sel <= EBTMR_RST_SRC;
    end
    else
      st <= next_st;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata           = {{(EBTMR_DATA_W-EBTMR_REG_W){1'b0}}, st.rdata};
  assign pready           = 1'b1;
  assign pslverr          = psel & penable & st.slverr;
  assign timer_output_pin = st.pin;
  assign match_irq        = st.irq;

endmodule

// ==== inc/ebtmr_pkg.sv ====
// Shared constants for the eight-bit event timer with PWM output
package ebtmr_pkg;

  // ==========================================================================
  // Bus and register geometry
  // ==========================================================================
  localparam int          EBTMR_DATA_W   = 32;
  localparam int          EBTMR_REG_W    = 8;
  localparam int          EBTMR_ADDR_W   = 18;
  localparam int          EBTMR_IDX_W    = 16;
  localparam int          EBTMR_IDX_LSB  = 2;
  localparam logic [1:0]  EBTMR_ALIGN_OK = 2'h0;

  // Register indices, byte address is four times the index
  localparam logic [15:0] EBTMR_IDX_SRC_A   = 16'hff6a;
  localparam logic [15:0] EBTMR_IDX_MODE_A  = 16'hff6b;
  localparam logic [15:0] EBTMR_IDX_COUNT_A = 16'hff6c;
  localparam logic [15:0] EBTMR_IDX_MATCH_A = 16'hff6d;
  localparam logic [15:0] EBTMR_IDX_SRC_B   = 16'hff8c;
  localparam logic [15:0] EBTMR_IDX_MODE_B  = 16'hff43;
  localparam logic [15:0] EBTMR_IDX_COUNT_B = 16'hff8d;
  localparam logic [15:0] EBTMR_IDX_MATCH_B = 16'hff8e;

  // ==========================================================================
  // Field positions of timer_mode_control
  // ==========================================================================
  localparam int EBTMR_BIT_RUN    = 7;
  localparam int EBTMR_BIT_PWM    = 6;
  localparam int EBTMR_BIT_FF_SET = 3;
  localparam int EBTMR_BIT_FF_CLR = 2;
  localparam int EBTMR_BIT_LEVEL  = 1;
  localparam int EBTMR_BIT_OUT_EN = 0;
  localparam int EBTMR_SRC_W      = 3;

  // ==========================================================================
  // Reset values and counter top value
  // ==========================================================================
  localparam logic [7:0] EBTMR_RST_COUNT = 8'h00;
  localparam logic [7:0] EBTMR_RST_MATCH = 8'h00;
  localparam logic [2:0] EBTMR_RST_SRC   = 3'h0;
  localparam logic [7:0] EBTMR_COUNT_TOP = 8'hff;

  // ==========================================================================
  // Count source codes and divider taps (log2 of the division)
  // ==========================================================================
  localparam logic [2:0] EBTMR_SRC_EV_FALL = 3'h0;
  localparam logic [2:0] EBTMR_SRC_EV_RISE = 3'h1;
  localparam logic [2:0] EBTMR_SRC_DIV_LO  = 3'h2;
  localparam int         EBTMR_PRESC_W     = 13;
  localparam int         EBTMR_TAP_N       = 6;
  localparam logic [3:0] EBTMR_TAPS_A [0:5] =
    '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'hd};
  localparam logic [3:0] EBTMR_TAPS_B [0:5] =
    '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hc};

endpackage

// ==== rtl/ebtmr_event_edge.sv ====
// Event input synchroniser and selectable edge detector
`timescale 1ns/10ps

module ebtmr_event_edge
  import ebtmr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic event_in,
  input  wire logic rising_sel,
  output logic      edge_pulse
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } ebtmr_edge_type;

  ebtmr_edge_type st;
  ebtmr_edge_type next_st;

  // Only the second stage and its history feed the edge compare
  always_comb
  begin
    next_st       = st;
    next_st.meta  = event_in;
    next_st.sync  = st.meta;
    next_st.prev  = st.sync;
    next_st.pulse = rising_sel ? (st.sync & ~st.prev)
                               : (~st.sync & st.prev);
  end

  // Register the whole state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign edge_pulse = st.pulse;

endmodule

// ==== sim/ebtmr_sva.sv ====
// Port-level assertions for the event timer, first channel map
`timescale 1ns/10ps

module ebtmr_sva
  import ebtmr_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [EBTMR_ADDR_W-1:0] paddr,
  input wire logic [EBTMR_DATA_W-1:0] pwdata,
  input wire logic [EBTMR_DATA_W-1:0] prdata,
  input wire logic                    pready,
  input wire logic                    timer_output_pin,
  input wire logic                    match_irq
);
  localparam logic [17:0] A_SRC  = {EBTMR_IDX_SRC_A, 2'h0};
  localparam logic [17:0] A_MODE = {EBTMR_IDX_MODE_A, 2'h0};
  localparam logic [17:0] A_CNT  = {EBTMR_IDX_COUNT_A, 2'h0};
  localparam logic [17:0] A_MAT  = {EBTMR_IDX_MATCH_A, 2'h0};
  logic [7:0] mat;
  logic [7:0] mode;
  logic [2:0] src;
  logic [1:0] age;
  logic [9:0] gap;
  logic       ok;
  logic       wr;
  logic       rd;
  logic       st;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ====================
  // Shadows of written registers; st means the mode has settled
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign st = age[1];

  // Gap counts cycles between interrupts, ok drops on any write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {mat, mode, src, age, gap, ok} <= '0;
    end
    else
    begin
      if (wr && paddr == A_MAT) mat <= pwdata[7:0];
      if (wr && paddr == A_MODE) mode <= pwdata[7:0];
      if (wr && paddr == A_SRC) src <= pwdata[2:0];
      age <= (wr && paddr == A_MODE) ? 2'h0 : age + {1'b0, ~&age};
      gap <= match_irq ? 10'h1 : gap + 10'h1;
      ok <= wr ? 1'b0 : (match_irq | ok);
    end

  // ====================
  // Assertions
  chk_output_off: assert property (
    st && !mode[0] |-> !timer_output_pin)
    else $error("pin high while output disabled");
  chk_pwm_quiet: assert property (st && mode[6] |-> !match_irq)
    else $error("interrupt raised in pwm mode");
  chk_stop_quiet: assert property (st && !mode[7] |-> !match_irq)
    else $error("interrupt raised while stopped");
  chk_pwm_idle: assert property (st && mode[7:6] == 2'h1 && mode[0]
    |-> timer_output_pin == mode[1]) else $error("stopped pwm not inactive");
  chk_square_toggle: assert property (
    match_irq && st && mode[1:0] == 2'h3 && !mode[6] ##1 st
    |-> timer_output_pin != $past(timer_output_pin))
    else $error("square output did not toggle");
  chk_irq_period: assert property (
    match_irq && ok && st && src == 3'h2 && !mode[6]
    |-> gap == {2'h0, mat} + 10'h1)
    else $error("bad irq spacing");
  chk_match_read: assert property (rd && paddr == A_MAT
    |-> prdata == {24'h0, mat}) else $error("compare readback wrong");
  chk_source_read: assert property (rd && paddr == A_SRC
    |-> prdata == {29'h0, src}) else $error("source readback wrong");
  chk_count_stop: assert property (
    rd && paddr == A_CNT && st && !mode[7]
    |-> prdata == 32'h0) else $error("stopped counter not zero");
endmodule

// ==== sim/ebtmr_pins.sv ====
// Far-side model: event signal source and output pin load
`timescale 1ns/10ps

module ebtmr_pins
(
  input  wire logic pclk,
  input  wire logic timer_output_pin,
  output logic      event_input_pin
);
  initial event_input_pin = 1'b0;

  // Toggle the event line n times, levels held 3 to 6 cycles
  task automatic edges(input int n);
    repeat (n)
    begin
      repeat (3 + $urandom_range(3)) @(posedge pclk);
      event_input_pin <= ~event_input_pin;
    end
    repeat (6) @(posedge pclk);
  endtask

  // Load side: cycles the pin spends high within a window
  task automatic high_time(input int span, output int hi);
    hi = 0;
    repeat (span)
    begin
      @(posedge pclk);
      hi += int'(timer_output_pin === 1'b1);
    end
  endtask
endmodule

// ==== sim/ebtmr_timer_tb.sv ====
// Self-checking bench for the first event timer channel
`timescale 1ns/10ps

module ebtmr_timer_tb
  import ebtmr_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        event_input_pin;
  logic        timer_output_pin;
  logic        match_irq;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          samples_checked;
  localparam int TAP [8] = '{0, 0, 0, 1, 2, 6, 8, 13};

  always #2 pclk = ~pclk;

  ebtmr_timer #(.SECOND_CHANNEL(1'b0)) DUT
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .event_input_pin, .timer_output_pin, .match_irq
  );
  ebtmr_pins u_pins (.pclk, .timer_output_pin, .event_input_pin);

  // ====================
  // Expected interrupt spacing and PWM high time
  function automatic int gap_of(int code, int cmp);
    return (cmp + 1) << TAP[code];
  endfunction
  function automatic int pwm_hi(int cmp, bit inv);
    int act;
    act = (cmp == 255) ? 0 : cmp + 1;
    return inv ? 256 - act : act;
  endfunction

  // One APB transfer, held until pready is seen high
  task automatic apb(input bit w, input logic [15:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, e}, rd);
  endtask

  // Stop first: source and mode only change while halted
  task automatic arm(input logic [7:0] s, input logic [7:0] cmp,
                     input logic [7:0] mode);
    apb(1'b1, EBTMR_IDX_MODE_A, 8'h00);
    apb(1'b1, EBTMR_IDX_SRC_A, s);
    apb(1'b1, EBTMR_IDX_MATCH_A, cmp);
    apb(1'b1, EBTMR_IDX_MODE_A, mode);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog, about three times the expected run
  initial
  begin
    #240000;
    bad_count++;
    print_verdict();
  end

  // ====================
  // Main sequence
  initial
  begin
    int         n;
    int         g;
    int         h;
    logic [7:0] v;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(86672));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(EBTMR_IDX_SRC_A, 8'h00);
    rchk(EBTMR_IDX_MATCH_A, 8'h00);
    rchk(EBTMR_IDX_COUNT_A, 8'h00);
    apb(1'b0, 16'h0000, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      apb(1'b1, EBTMR_IDX_MATCH_A, v);
      rchk(EBTMR_IDX_MATCH_A, v);
    end
    $display("test compare done");
    for (int c = 2; c < 8; c++)
    begin
      v = (c > 5) ? 8'h00 : 8'($urandom_range(7));
      arm(8'(c), v, 8'h83);
      rchk(EBTMR_IDX_SRC_A, 8'(c));
      do @(posedge pclk); while (match_irq !== 1'b1);
      g = 0;
      do
      begin
        @(posedge pclk);
        g++;
      end
      while (match_irq !== 1'b1);
      chk("irq gap", gap_of(c, v), g);
    end
    $display("test divider done");
    for (int c = 0; c < 2; c++)
    begin
      arm(8'(c), 8'hff, 8'h80);
      n = 2 * $urandom_range(7) + 1;
      h = int'(event_input_pin);
      u_pins.edges(n);
      apb(1'b1, EBTMR_IDX_COUNT_A, 8'h55);
      rchk(EBTMR_IDX_COUNT_A, 8'((n + int'(h != c)) / 2));
      apb(1'b1, EBTMR_IDX_MODE_A, 8'h00);
      rchk(EBTMR_IDX_COUNT_A, 8'h00);
    end
    $display("test event done");
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'($urandom_range(254));
      arm(8'h02, v, {6'h30, i[0], 1'b1});
      repeat (300) @(posedge pclk);
      u_pins.high_time(256, h);
      chk("pwm high", pwm_hi(v, i[0]), h);
    end
    apb(1'b1, EBTMR_IDX_MODE_A, 8'h43);
    repeat (4) @(posedge pclk);
    chk("stopped pwm", 32'h1, {31'h0, timer_output_pin});
    apb(1'b1, EBTMR_IDX_MODE_A, 8'h00);
    repeat (4) @(posedge pclk);
    chk("disabled pin", 32'h0, {31'h0, timer_output_pin});
    // Force the output flip-flop both ways; the set bit reads back zero
    apb(1'b1, EBTMR_IDX_MODE_A, 8'h09);
    rchk(EBTMR_IDX_MODE_A, 8'h01);
    repeat (4) @(posedge pclk);
    chk("forced high pin", 32'h1, {31'h0, timer_output_pin});
    apb(1'b1, EBTMR_IDX_MODE_A, 8'h05);
    repeat (4) @(posedge pclk);
    chk("forced low pin", 32'h0, {31'h0, timer_output_pin});
    $display("test pwm done");
    print_verdict();
  end
endmodule

bind ebtmr_timer ebtmr_sva u_sva
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .timer_output_pin, .match_irq
);
